// File: core/delay_detect.sv
// Timed threshold detector counting tenth-second ticks
`timescale 1ns/100ps
module delay_detect #(
  parameter int TW = 8
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic          i_clk_en,
  // Condition and timing
  input  wire logic          i_tick,
  input  wire logic          i_cond,
  input  wire logic [TW-1:0] i_time,
  // Result
  output logic               o_det
);

  logic [TW:0] cnt_r;

  // Count ticks while the condition holds, restart when it lapses
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (i_clk_en) begin
      if (!i_cond) begin
        cnt_r <= '0;
      end else if (i_tick && !(&cnt_r)) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Detected once the held time is strictly longer than the setting
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_det <= 1'b0;
    end else if (i_clk_en) begin
      o_det <= i_cond && (cnt_r > {1'b0, i_time});
    end
  end

endmodule // delay_detect

// File: core/pid_output_supervision.sv
// PID output shaping, feedback supervision, sleep and target ramp
// Summary of operation
// RULE1: Sign invert set negates the PID output.
// RULE2: PID output is multiplied by gain 0.00..25.00, default 1.00; the gain register takes up to 40.95 without clamping.
// RULE3: Reverse select 0 clamps negative output to zero, stopping drive.
// RULE4: Reverse select 1 runs the motor reverse on negative output.
// RULE5: Modes 3 and 4 ignore reverse select and leave output unlimited.
// RULE6: Low feedback detected when below level longer than low time.
// RULE7: High feedback detected likewise above the high level and time.
// RULE8: Supervision 0 sets flags only and drops them back in range.
// RULE9: Supervision 1 adds alarm and general alarm output, keeps running.
// RULE10: Supervision 2 raises a fault, fault output, and stops the motor.
// RULE11: Supervision 3..5 act as 0..2 even with PID disabled.
// RULE12: Sleep entered when level stays below sleep level past delay.
// RULE13: Sleep left when level stays above sleep level past delay.
// RULE14: Sleep stops the motor by the selected stopping method.
// RULE15: Target changes ramp at programmed time, zero means no ramp.
// RULE16: Soft-start input assignment bypasses the target ramp.
// RULE17: Stored target used only when stored target select is 1.
// RULE18: Stored target held as 0.00..100.00 % of maximum, default 0.
// RULE19: Display units 0 Hz, 1 percent default, 2 r/min, 3 user.
// RULE20: Modes 3 and 4 add PID output to frequency command.
// RULE21: High level defaults to 100 %, high time to 1.0 s.
// RULE22: Delay timers restart whenever the condition lapses early.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pid_sup_defs.svh"
module pid_output_supervision
  import pid_sup_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  // Register port
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  // Loop signals, 0.01 % of maximum frequency
  input  wire logic signed [15:0] i_pid_out,
  input  wire logic signed [15:0] i_freq_cmd,
  input  wire logic        [15:0] i_feedback,
  input  wire logic        [15:0] i_target_ext,
  input  wire logic               i_soft_start_assigned,
  // Drive command
  output logic             [15:0] o_freq_out,
  output logic                    o_reverse,
  output logic                    o_stop_req,
  output logic             [1:0]  o_stop_method,
  output logic                    o_pid_feedback_path,
  output logic             [15:0] o_target,
  output logic             [1:0]  o_display_units,
  // Supervision outputs
  output logic                    o_low_fb_flag,
  output logic                    o_high_fb_flag,
  output logic                    o_alarm,
  output logic                    o_fault,
  output logic                    o_low_feedback_event,
  output logic                    o_high_feedback_event,
  output logic                    o_sleep
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] sat16(
    input logic signed [28:0] x);
    if (x > 29'sd32767) sat16 = 16'sh7FFF;
    else if (x < -29'sd32767) sat16 = -16'sh7FFF;
    else sat16 = x[15:0];
  endfunction

  function automatic logic [15:0] mag16(input logic signed [15:0] x);
    mag16 = x[15] ? 16'(-x) : x;
  endfunction

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  logic        invert_r, rev_sel_r, bypass_r, stored_sel_r;
  logic [2:0]  mode_r, sup_sel_r;
  logic [1:0]  units_r, stop_method_r;
  logic [11:0] gain_r;
  logic [15:0] low_lvl_r, high_lvl_r, sleep_lvl_r, ramp_time_r;
  logic [15:0] stored_r;
  logic [7:0]  low_time_r, high_time_r, sleep_dly_r;
  logic        wr_en, fault_clr;

  assign wr_en     = i_clk_en && i_wr;
  assign fault_clr = wr_en && (i_addr == `ADDR_STATUS) &&
                     i_wdata[`STATUS_FAULT];

  // Register writes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      invert_r      <= 1'b0;
      rev_sel_r     <= 1'b0;
      bypass_r      <= 1'b0;
      stored_sel_r  <= 1'b0;                      // RULE17
      mode_r        <= 3'h0;
      sup_sel_r     <= 3'h0;
      units_r       <= `RST_UNITS;                // RULE19
      stop_method_r <= 2'h0;
      gain_r        <= `RST_GAIN;                 // RULE2
      low_lvl_r     <= `RST_LOW_LVL;              // RULE6
      low_time_r    <= `RST_LOW_TIME;             // RULE6
      high_lvl_r    <= `RST_HIGH_LVL;             // RULE21
      high_time_r   <= `RST_HIGH_TIME;            // RULE21
      sleep_lvl_r   <= 16'h0000;
      sleep_dly_r   <= `RST_SLEEP_DLY;            // RULE12
      ramp_time_r   <= 16'h0000;                  // RULE15
      stored_r      <= 16'h0000;                  // RULE18
    end else if (wr_en) begin
      case (i_addr)
        `ADDR_CTRL: begin
          invert_r      <= i_wdata[`CTRL_INVERT];
          rev_sel_r     <= i_wdata[`CTRL_REV_SEL];
          bypass_r      <= i_wdata[`CTRL_BYPASS];
          stored_sel_r  <= i_wdata[`CTRL_STORED_SEL];
          mode_r        <= i_wdata[`CTRL_MODE_LO +: 3];
          sup_sel_r     <= i_wdata[`CTRL_SUP_LO +: 3];
          units_r       <= i_wdata[`CTRL_UNITS_LO +: 2];
          stop_method_r <= i_wdata[`CTRL_STOP_LO +: 2];
        end
        `ADDR_GAIN:      gain_r      <= i_wdata[11:0];
        `ADDR_LOW_LVL:   low_lvl_r   <= i_wdata[15:0];
        `ADDR_LOW_TIME:  low_time_r  <= i_wdata[7:0];
        `ADDR_HIGH_LVL:  high_lvl_r  <= i_wdata[15:0];
        `ADDR_HIGH_TIME: high_time_r <= i_wdata[7:0];
        `ADDR_SLEEP_LVL: sleep_lvl_r <= i_wdata[15:0];
        `ADDR_SLEEP_DLY: sleep_dly_r <= i_wdata[7:0];
        `ADDR_RAMP_TIME: ramp_time_r <= i_wdata[15:0];
        `ADDR_STORED: begin                       // RULE18
          stored_r <= (i_wdata[15:0] > `FULL_SCALE) ?
                      `FULL_SCALE : i_wdata[15:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Tenth-second tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic        tick_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else if (i_clk_en) begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      if (tick_cnt_r == 32'(TICK_CYCLES - 1)) tick_cnt_r <= 32'h0;
      else tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Output shaping
  // ----------------------------------------------------------------
  logic               pid_en, mode_add;
  logic signed [15:0] pid_sgn, pid_g, sum_s;
  logic        [15:0] freq_nxt;
  logic               rev_nxt;

  assign pid_en   = (mode_r != 3'h0);
  assign mode_add = (mode_r == 3'h3) || (mode_r == 3'h4);
  assign pid_sgn  = invert_r ? sat16(-29'(i_pid_out)) : i_pid_out; // RULE1
  assign pid_g    = sat16(29'((29'(pid_sgn) * $signed({1'b0, gain_r}))
                          / `GAIN_UNITY));                      // RULE2
  assign sum_s    = sat16(29'(i_freq_cmd) + 29'(pid_g));        // RULE20

  // Direction and magnitude of the frequency sent to the drive
  always_comb begin
    rev_nxt  = 1'b0;
    freq_nxt = 16'h0000;
    if (!pid_en) begin
      rev_nxt  = i_freq_cmd[15];
      freq_nxt = mag16(i_freq_cmd);
    end else if (mode_add) begin
      rev_nxt  = sum_s[15];                       // RULE5
      freq_nxt = mag16(sum_s);                    // RULE5
    end else begin
      if (pid_g[15] && rev_sel_r) begin
        rev_nxt  = 1'b1;                          // RULE4
        freq_nxt = mag16(pid_g);                  // RULE4
      end else if (!pid_g[15]) begin
        freq_nxt = pid_g;
      end
      if (!bypass_r && freq_nxt > `FULL_SCALE) freq_nxt = `FULL_SCALE;
    end
  end

  // ----------------------------------------------------------------
  // Feedback supervision
  // ----------------------------------------------------------------
  logic sup_on, low_det, high_det, is_flag, is_alarm, is_fault;
  logic fault_nxt;

  assign sup_on   = (sup_sel_r >= 3'h3) || pid_en;          // RULE11
  assign is_flag  = (sup_sel_r == 3'h0) || (sup_sel_r == 3'h3);
  assign is_alarm = (sup_sel_r == 3'h1) || (sup_sel_r == 3'h4);
  assign is_fault = (sup_sel_r == 3'h2) || (sup_sel_r == 3'h5);

  delay_detect #(.TW(8)) u_low (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_tick   (tick_r),
    .i_cond   (sup_on && (i_feedback < low_lvl_r)),          // RULE6
    .i_time   (low_time_r),
    .o_det    (low_det)
  );

  delay_detect #(.TW(8)) u_high (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_tick   (tick_r),
    .i_cond   (sup_on && (i_feedback > high_lvl_r)),         // RULE7
    .i_time   (high_time_r),
    .o_det    (high_det)
  );

  // Fault is sticky until software clears it, a new event wins
  assign fault_nxt = (is_fault && (low_det || high_det)) ||  // RULE10
                     (o_fault && !fault_clr);

  // Flags and alarm follow the detectors, faults latch
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_low_fb_flag         <= 1'b0;
      o_high_fb_flag        <= 1'b0;
      o_alarm               <= 1'b0;
      o_fault               <= 1'b0;
      o_low_feedback_event  <= 1'b0;
      o_high_feedback_event <= 1'b0;
    end else if (i_clk_en) begin
      o_low_fb_flag  <= low_det && (is_flag || is_alarm);   // RULE8
      o_high_fb_flag <= high_det && (is_flag || is_alarm);  // RULE8
      o_alarm        <= is_alarm && (low_det || high_det);  // RULE9
      o_fault        <= fault_nxt;                          // RULE10
      o_low_feedback_event <= (is_alarm && low_det) ||
        (is_fault && low_det) || (o_low_feedback_event && o_fault &&
        !fault_clr);
      o_high_feedback_event <= (is_alarm && high_det) ||
        (is_fault && high_det) || (o_high_feedback_event && o_fault &&
        !fault_clr);
    end
  end

  // ----------------------------------------------------------------
  // Sleep
  // ----------------------------------------------------------------
  sleep_state_t       state_r;
  logic signed [16:0] lvl_s, slp_s;
  logic               enter_det, exit_det, sleep_nxt;

  assign lvl_s = pid_en ? 17'(pid_g) : 17'(i_freq_cmd);
  assign slp_s = $signed({1'b0, sleep_lvl_r});

  delay_detect #(.TW(8)) u_enter (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_tick   (tick_r),
    .i_cond   ((state_r == ST_AWAKE) && (lvl_s < slp_s)),    // RULE12
    .i_time   (sleep_dly_r),
    .o_det    (enter_det)
  );

  delay_detect #(.TW(8)) u_exit (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_tick   (tick_r),
    .i_cond   ((state_r == ST_ASLEEP) && (lvl_s > slp_s)),   // RULE13
    .i_time   (sleep_dly_r),
    .o_det    (exit_det)
  );

  assign sleep_nxt = (state_r == ST_AWAKE) ? enter_det : !exit_det;

  // Sleep state machine
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= ST_AWAKE;
    end else if (i_clk_en) begin
      unique case (state_r)
        ST_AWAKE:  if (enter_det) state_r <= ST_ASLEEP;      // RULE12
        ST_ASLEEP: if (exit_det) state_r <= ST_AWAKE;        // RULE13
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Target selection and ramp
  // ----------------------------------------------------------------
  logic [15:0] target_src;
  logic        ramp_off;
  logic [47:0] acc_r, ramp_span;

  assign target_src = stored_sel_r ? stored_r : i_target_ext; // RULE17
  assign ramp_off   = i_soft_start_assigned ||               // RULE16
                      (ramp_time_r == 16'h0000);             // RULE15
  assign ramp_span  = 48'(ramp_time_r) * 48'(TICK_CYCLES);

  // One unit step each time full scale per ramp time accumulates
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_target <= 16'h0000;
      acc_r    <= 48'h0;
    end else if (i_clk_en) begin
      if (ramp_off) begin
        o_target <= target_src;                              // RULE16
        acc_r    <= 48'h0;
      end else if (o_target == target_src) begin
        acc_r <= 48'h0;
      end else if (acc_r + `RAMP_STEP >= ramp_span) begin    // RULE15
        acc_r    <= acc_r + `RAMP_STEP - ramp_span;
        o_target <= (o_target < target_src) ? o_target + 16'h1 :
                    o_target - 16'h1;
      end else begin
        acc_r <= acc_r + `RAMP_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive command outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_freq_out          <= 16'h0000;
      o_reverse           <= 1'b0;
      o_stop_req          <= 1'b0;
      o_stop_method       <= 2'h0;
      o_pid_feedback_path <= 1'b0;
      o_display_units     <= `RST_UNITS;
      o_sleep             <= 1'b0;
    end else if (i_clk_en) begin
      o_freq_out          <= freq_nxt;                       // RULE3
      o_reverse           <= rev_nxt;
      o_stop_req          <= fault_nxt || sleep_nxt;         // RULE14
      o_stop_method       <= stop_method_r;                  // RULE14
      o_pid_feedback_path <= (mode_r == 3'h2) ||
                             (mode_r == 3'h4);               // RULE20
      o_display_units     <= units_r;                        // RULE19
      o_sleep             <= sleep_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else if (i_clk_en) begin
      o_rdata <= 32'h0;
      if (i_rd) begin
        case (i_addr)
          `ADDR_CTRL: o_rdata <= 32'({stop_method_r, units_r,
            sup_sel_r, mode_r, stored_sel_r, bypass_r, rev_sel_r,
            invert_r});
          `ADDR_GAIN:      o_rdata <= 32'(gain_r);
          `ADDR_LOW_LVL:   o_rdata <= 32'(low_lvl_r);
          `ADDR_LOW_TIME:  o_rdata <= 32'(low_time_r);
          `ADDR_HIGH_LVL:  o_rdata <= 32'(high_lvl_r);
          `ADDR_HIGH_TIME: o_rdata <= 32'(high_time_r);
          `ADDR_SLEEP_LVL: o_rdata <= 32'(sleep_lvl_r);
          `ADDR_SLEEP_DLY: o_rdata <= 32'(sleep_dly_r);
          `ADDR_RAMP_TIME: o_rdata <= 32'(ramp_time_r);
          `ADDR_STORED:    o_rdata <= 32'(stored_r);
          `ADDR_STATUS: o_rdata <= 32'({o_reverse, o_sleep, o_fault,
            o_alarm, high_det, low_det});
          `ADDR_TARGET:    o_rdata <= 32'(o_target);
          `ADDR_OUTPUT:    o_rdata <= 32'(o_freq_out);
          default:         o_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gain_unity_pass: assert property (@(posedge i_clock) // RULE2
    disable iff (!i_rst_n)
    (i_clk_en && mode_r == 3'h1 && gain_r == `RST_GAIN && !invert_r &&
     !i_pid_out[15] && i_pid_out <= $signed(`FULL_SCALE))
    |=> o_freq_out == $past(i_pid_out))
    else $error("unity gain output differs from PID output");

  a_invert_negates: assert property (@(posedge i_clock) // RULE1
    disable iff (!i_rst_n)
    (i_clk_en && mode_r == 3'h1 && gain_r == `RST_GAIN && invert_r &&
     rev_sel_r && i_pid_out > 16'sh0000 && i_pid_out < 16'sh2710)
    |=> o_reverse && o_freq_out == $past(i_pid_out))
    else $error("inverted output not reversed");

  a_neg_clamp_zero: assert property (@(posedge i_clock) // RULE3
    disable iff (!i_rst_n)
    (i_clk_en && mode_r == 3'h2 && !rev_sel_r && pid_g[15])
    |=> !o_reverse && o_freq_out == 16'h0000)
    else $error("negative output not clamped to zero");

  a_add_mode_rev: assert property (@(posedge i_clock) // RULE5
    disable iff (!i_rst_n)
    (i_clk_en && mode_add && !rev_sel_r && sum_s[15]) |=> o_reverse)
    else $error("add mode did not ignore reverse select");

  a_flag_no_alarm: assert property (@(posedge i_clock) // RULE8
    disable iff (!i_rst_n)
    $past(i_clk_en && is_flag) |-> !o_alarm && !o_low_feedback_event)
    else $error("flag mode raised an alarm");

  a_alarm_has_flag: assert property (@(posedge i_clock) // RULE9
    disable iff (!i_rst_n)
    o_alarm |-> (o_low_fb_flag || o_high_fb_flag))
    else $error("alarm without a feedback flag");

  a_fault_stops: assert property (@(posedge i_clock) // RULE10
    disable iff (!i_rst_n)
    (o_fault || o_sleep) |-> o_stop_req)
    else $error("fault or sleep without stop request");

  a_soft_start_bypass: assert property (@(posedge i_clock) // RULE16
    disable iff (!i_rst_n)
    (i_clk_en && i_soft_start_assigned && !stored_sel_r)
    |=> o_target == $past(i_target_ext))
    else $error("target ramp not bypassed");

  a_sleep_method: assert property (@(posedge i_clock) // RULE14
    disable iff (!i_rst_n)
    o_sleep |-> o_stop_req && o_stop_method == $past(stop_method_r))
    else $error("sleep stop method mismatch");

endmodule // pid_output_supervision

// File: core/pid_sup_defs.svh
// Constants for the PID output supervision block
`ifndef PID_SUP_DEFS_SVH
`define PID_SUP_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL        8'h00
`define ADDR_GAIN        8'h04
`define ADDR_LOW_LVL     8'h08
`define ADDR_LOW_TIME    8'h0C
`define ADDR_HIGH_LVL    8'h10
`define ADDR_HIGH_TIME   8'h14
`define ADDR_SLEEP_LVL   8'h18
`define ADDR_SLEEP_DLY   8'h1C
`define ADDR_RAMP_TIME   8'h20
`define ADDR_STORED      8'h24
`define ADDR_STATUS      8'h28
`define ADDR_TARGET      8'h2C
`define ADDR_OUTPUT      8'h30

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTRL_INVERT      0
`define CTRL_REV_SEL     1
`define CTRL_BYPASS      2
`define CTRL_STORED_SEL  3
`define CTRL_MODE_LO     4
`define CTRL_SUP_LO      7
`define CTRL_UNITS_LO    10
`define CTRL_STOP_LO     12
`define STATUS_FAULT     3

// ----------------------------------------------------------------
// Reset values and scales (levels in 0.01 %, times in 0.1 s)
// ----------------------------------------------------------------
`define RST_UNITS        2'h1
`define RST_GAIN         12'h064
`define GAIN_UNITY       100
`define RST_LOW_LVL      16'h0000
`define RST_LOW_TIME     8'h0A
`define RST_HIGH_LVL     16'h2710
`define RST_HIGH_TIME    8'h0A
`define RST_SLEEP_DLY    8'h00
`define FULL_SCALE       16'h2710
`define RAMP_STEP        48'h0000_0000_2710

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS  10
`define TIME_UNIT_NS     100000000
`define TICK_CYCLES      (`TIME_UNIT_NS / `CLOCK_PERIOD_NS)

`endif

// File: core/pid_sup_pkg.sv
// Types shared by the PID output supervision block
package pid_sup_pkg;

  // Sleep state, one-hot
  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b01,
    ST_ASLEEP = 2'b10
  } sleep_state_t;

endpackage

// File: testbench/loop_partner.sv
// Loop partner model: PID core, frequency source and feedback sensor
`timescale 1ns/100ps
module loop_partner (
  // Clock and requested values
  input  wire logic        i_clock,
  input  wire logic [15:0] i_pid_set,
  input  wire logic [15:0] i_cmd_set,
  input  wire logic [15:0] i_fb_set,
  // Values seen by the block
  output logic      [15:0] o_pid_out = 16'h0000,
  output logic      [15:0] o_freq_cmd = 16'h0000,
  output logic      [15:0] o_feedback = 16'h0000
);
  // Sources settle one cycle after a request
  always @(posedge i_clock) begin
    o_pid_out  <= i_pid_set;
    o_freq_cmd <= i_cmd_set;
    o_feedback <= i_fb_set;
  end
endmodule // loop_partner

// File: testbench/pid_output_supervision_bench.sv
// Random and corner-case bench for the PID output supervision block
`timescale 1ns/100ps
`include "pid_sup_defs.svh"
module pid_output_supervision_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock = 0, rst_n = 0, wr = 0, rd = 0, ss = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rs = 32'h21;
  logic [15:0] pid = 0, cmd = 0, fb = 16'h0200, tgt = 16'h0500;
  logic [15:0] pid_w, cmd_w, fb_w, fout, trg;
  logic [1:0]  units, smeth;
  logic        rev, stop, slp, lf, hf, alm, flt, lev, pfp, hev, ce = 1;
  int          error_cnt = 0, cmp_count = 0, g, p, s;
  // Clock
  always #5 clock = ~clock;
  // Partner and block
  loop_partner PART (.i_clock(clock), .i_pid_set(pid), .i_cmd_set(cmd),
    .i_fb_set(fb), .o_pid_out(pid_w), .o_freq_cmd(cmd_w),
    .o_feedback(fb_w));
  pid_output_supervision #(.TICK_CYCLES(10)) DUT (.i_clock(clock),
    .i_rst_n(rst_n), .i_clk_en(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pid_out(pid_w),
    .i_freq_cmd(cmd_w), .i_feedback(fb_w), .i_target_ext(tgt),
    .i_soft_start_assigned(ss), .o_freq_out(fout), .o_reverse(rev),
    .o_stop_req(stop), .o_stop_method(smeth), .o_pid_feedback_path(pfp),
    .o_target(trg), .o_display_units(units), .o_low_fb_flag(lf),
    .o_high_fb_flag(hf), .o_alarm(alm), .o_fault(flt),
    .o_low_feedback_event(lev), .o_high_feedback_event(hev), .o_sleep(slp));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] ctl(int m, int v, int r, int i, int t);
    return 32'((t << 12) | (1 << 10) | (v << 7) | (m << 4) | (r << 1) | i);
  endfunction
  // Expected direction and magnitude, limited to full scale
  function automatic logic [16:0] exp_f(int p, int g, int i, int r);
    int v = (i ? -p : p) * g / 100;
    if (v < 0) return r ? {1'b1, 16'(v < -10000 ? 10000 : -v)} : 17'h0;
    return {1'b0, 16'(v > 10000 ? 10000 : v)};
  endfunction
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    cmp_count++;
    if (gv !== ev) begin
      error_cnt++;
      $display("wrong value at %0t: %h vs %h", $time, gv, ev);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] ev);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, ev);
  endtask
  task automatic setin(input int pv, input int cv, input logic [15:0] f);
    @(posedge clock);
    pid <= 16'(pv);
    cmd <= 16'(cv);
    fb  <= f;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rreg(`ADDR_GAIN, 32'h64);
    rreg(`ADDR_LOW_TIME, 32'h0A);
    rreg(`ADDR_HIGH_LVL, 32'h2710);
    rreg(8'hFC, 32'h0);
    chk(units, 32'h1);
    wreg(`ADDR_SLEEP_DLY, 32'hFF);
    for (int k = 0; k < 24; k++) begin
      g = k == 0 ? 0 : k == 1 ? 2500 : rnd() % 2501;
      p = int'(rnd() % 20001) - 10000;
      s = rnd() % 4;
      wreg(`ADDR_GAIN, g);
      wreg(`ADDR_CTRL, ctl(1 + k % 2, 0, s / 2, s % 2, 0));
      setin(p, 0, 16'h0200);
      cyc(3);
      chk({rev, fout}, exp_f(p, g, s % 2, s / 2));
      chk(pfp, k % 2);
    end
    wreg(`ADDR_GAIN, 32'h64);
    for (int m = 3; m < 5; m++) begin
      wreg(`ADDR_CTRL, ctl(m, 0, 0, 0, 0));
      setin(-3000, 1000, 16'h0200);
      cyc(3);
      chk({rev, fout}, 17'h107D0);
      setin(3000, 9000, 16'h0200);
      cyc(3);
      chk({rev, fout}, 17'h02EE0);
      chk(pfp, m == 4);
    end
    wreg(`ADDR_LOW_LVL, 32'h100);
    wreg(`ADDR_LOW_TIME, 32'h0);
    for (int v = 0; v < 6; v++) begin
      s = v % 3;
      wreg(`ADDR_CTRL, ctl(v < 3, v, 0, 0, 0));
      setin(0, 0, 16'h0000);
      cyc(40);
      chk({lf, alm, flt, lev, stop},
          {s != 2, s == 1, s == 2, s != 0, s == 2});
      setin(0, 0, 16'h0200);
      cyc(5);
      chk({lf, alm, flt}, {2'b00, s == 2});
      wreg(`ADDR_STATUS, 32'h8);
      cyc(2);
      chk(flt, 32'h0);
    end
    wreg(`ADDR_CTRL, ctl(1, 1, 0, 0, 0));
    wreg(`ADDR_LOW_TIME, 32'h2);
    repeat (4) begin
      setin(0, 0, 16'h0000);
      cyc(14);
      setin(0, 0, 16'h0200);
    end
    cyc(3);
    chk(lf, 32'h0);
    setin(0, 0, 16'h0000);
    cyc(45);
    chk(lf, 32'h1);
    wreg(`ADDR_HIGH_LVL, 32'h1000);
    wreg(`ADDR_HIGH_TIME, 32'h0);
    setin(0, 0, 16'h2000);
    cyc(40);
    chk({hf, lf}, 32'h2);
    chk({hev, alm}, 32'h3);
    wreg(`ADDR_CTRL, ctl(0, 0, 0, 0, 2));
    wreg(`ADDR_SLEEP_LVL, 32'h100);
    wreg(`ADDR_SLEEP_DLY, 32'h0);
    setin(0, 16'h0050, 16'h0200);
    cyc(40);
    chk({slp, stop, smeth}, 32'hE);
    setin(0, 16'h0500, 16'h0200);
    cyc(40);
    chk({slp, fout}, 32'h0500);
    wreg(`ADDR_STORED, 32'h3000);
    rreg(`ADDR_STORED, 32'h2710);
    chk(trg, 32'h0500);
    wreg(`ADDR_RAMP_TIME, 32'h1);
    @(posedge clock);
    tgt <= 16'h0600;
    cyc(5);
    chk(trg == 16'h0600, 32'h0);
    cyc(300);
    chk(trg, 32'h0600);
    @(posedge clock);
    ss  <= 1'b1;
    tgt <= 16'h0700;
    cyc(3);
    chk(trg, 32'h0700);
    // Clock enable low must freeze the target
    @(posedge clock);
    ce  <= 1'b0;
    tgt <= 16'h0800;
    cyc(3);
    chk(trg, 32'h0700);
    @(posedge clock);
    ce <= 1'b1;
    cyc(2);
    chk(trg, 32'h0800);
    for (int u = 0; u < 4; u++) begin
      wreg(`ADDR_CTRL, u << 10);
      cyc(2);
      chk(units, u);
    end
    tally_and_finish();
  end
endmodule // pid_output_supervision_bench
